// [bench/bus_partner.sv]
// other master on the shared two-wire bus, steered by the bench
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       lclk,
   input  wire logic       hold_sda,
   input  wire logic       stretch,
   input  wire logic [3:0] arb_at,
   output wire logic       scl_pull,
   output wire logic       sda_pull
);
   logic [3:0] rise_q = 4'h0;
   logic       str_q = 1'b0;
   // count clock rises while a lost-arbitration point is armed
   always @(posedge scl)
   begin
      rise_q <= (arb_at == 4'h0) ? 4'h0 : rise_q + 4'h1;
   end
   // drive a zero from the chosen rise on, as a rival sending 0
   assign sda_pull = hold_sda | (arb_at != 4'h0 && rise_q >= arb_at);
   // hold the clock low until the second link clock rise after each fall
   always @(negedge scl)
   begin
      if (stretch)
      begin
         str_q = 1'b1;
         repeat (2) @(posedge lclk);
         str_q = 1'b0;
      end
   end
   assign scl_pull = str_q;
endmodule // bus_partner
`default_nettype wire

// [bench/i2c_arb_sva.sv]
// pin-level assertions for the collision arbiter port
`timescale 1ns/1ps
`default_nettype none
`include "i2c_arb_map.vh"
module i2c_arb_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe
);
   wire        acc = psel && penable && pready;
   wire        st_rd = acc && !pwrite && paddr == `OFS_STAT;
   logic       bcol_q;
   logic       dis_q;
   logic [6:0] rate_q;
   logic [7:0] hi_q;
   // software view mirrored from completed transfers; high time of scl
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bcol_q <= 1'b0;
         dis_q <= 1'b1;
         rate_q <= `RATE_RST;
         hi_q <= 8'h00;
      end
      else
      begin
         if (st_rd && prdata[`STAT_BCOL])
            bcol_q <= 1'b1;
         else if (acc && pwrite && paddr == `OFS_STAT && pwdata[0])
            bcol_q <= 1'b0;
         if (acc && pwrite && paddr == `OFS_CTRL)
            dis_q <= !pwdata[`CTRL_EN];
         if (acc && pwrite && paddr == `OFS_RATE)
            rate_q <= pwdata[6:0];
         hi_q <= scl_oe ? 8'h00 : hi_q + {7'h00, scl_i && hi_q != 8'hff};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence held_off;
      dis_q [*3];
   endsequence
   chk_apb_ready: assert property (apb_setup |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_slverr_map: assert property (pready |->
      pslverr == (paddr > `OFS_BUF || paddr[1:0] != 2'b00))
      else $error("slave error wrong for address");
   chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 0)
      else $error("unmapped read not zero");
   chk_bcol_sticky: assert property (st_rd && bcol_q |-> prdata[0])
      else $error("collision flag lost");
   chk_clk_high: assert property ($rose(scl_oe) |-> hi_q > {1'b0, rate_q})
      else $error("clock high time short");
   chk_off_quiet: assert property (held_off |-> !scl_oe && !sda_oe)
      else $error("disabled port drives a line");
   chk_seen_clear: assert property (st_rd && dis_q |-> prdata[4:3] == 0)
      else $error("seen bits set while disabled");
   chk_open_drain: assert property (scl_oe || sda_oe |-> !(scl_o || sda_o))
      else $error("line driven high");
endmodule // i2c_arb_sva
`default_nettype wire

// [bench/i2c_master_bus_collision_arbiter_tb.sv]
// self-checking bench for the collision arbiter port
`timescale 1ns/1ps
`default_nettype none
`include "i2c_arb_map.vh"
module i2c_master_bus_collision_arbiter_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        hold_sda = 1'b0;
   logic        stretch = 1'b0;
   logic [3:0]  arb_at = 4'h0;
   logic        lclk = 1'b0;
   logic        last_err;
   logic [31:0] r;
   logic [7:0]  sh;
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
   wire         scl_pull, sda_pull;
   // wired-AND line levels
   wire         scl = ~(scl_oe | scl_pull);
   wire         sda = ~(sda_oe | sda_pull);
   i2c_master_bus_collision_arbiter i2c_master_bus_collision_arbiter_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   bus_partner bus_partner_inst (
      .scl(scl), .sda(sda), .lclk(lclk), .hold_sda(hold_sda),
      .stretch(stretch), .arb_at(arb_at), .scl_pull(scl_pull),
      .sda_pull(sda_pull));
   // system clock, and link clock only while stretching
   initial forever #25 pclk = ~pclk;
   initial forever #200 lclk = stretch & ~lclk;
   // cycle ceiling against hangs
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         wrap_up;
      end
   end
   // one bus transfer, read data left in r
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no timeout of its own: ends on pready, else only the cycle ceiling ends it
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(r & m, e);
   endtask
   task automatic oe_is(input logic [1:0] e);
      chk({30'h0, scl_oe, sda_oe}, {30'h0, e});
   endtask
   // poll status until the sequencer is idle
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, `OFS_STAT, 32'h0);
         n++;
      end
      while (r[`STAT_BUSY] !== 1'b0 && n < 2000);
      chk({31'h0, r[`STAT_BUSY]}, 32'h0);
   endtask
   // reset values, rate write, unmapped place
   task automatic t_reset;
      apb(1'b0, `OFS_RATE, 32'h0);
      chk(r, {25'h0, `RATE_RST});
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(r, 32'h0);
      stat(32'h7f, 32'h0);
      apb(1'b1, `OFS_RATE, 32'h5);
      apb(1'b0, `OFS_RATE, 32'h0);
      chk(r, 32'h5);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      chk(r, 32'h0);
   endtask
   // start into a data line already held low
   task automatic t_start_col;
      apb(1'b1, `OFS_CTRL, 32'h1);
      hold_sda <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b1, `OFS_CTRL, 32'h3);
      wait_idle;
      stat(32'h1, 32'h1);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(r, 32'h1);
      oe_is(2'b00);
      hold_sda <= 1'b0;
      repeat (6) @(posedge pclk);
      stat(32'h1, 32'h1);
      apb(1'b1, `OFS_STAT, 32'h3);
      stat(32'h3, 32'h0);
   endtask
   // start, then one byte under clock stretching
   task automatic t_byte;
      stretch <= 1'b1;
      apb(1'b1, `OFS_CTRL, 32'h3);
      wait_idle;
      stat(32'h1, 32'h0);
      oe_is(2'b11);
      fork
         repeat (8) @(posedge scl) sh = {sh[6:0], sda};
      join_none
      apb(1'b1, `OFS_BUF, 32'ha5);
      wait_idle;
      chk({24'h0, sh}, 32'ha5);
      stat(32'h47, 32'h42);
      // let the last stretch end before the link clock stops
      repeat (20) @(posedge pclk);
      stretch <= 1'b0;
   endtask
   // arbitration lost mid-byte, then a fresh byte
   task automatic t_byte_col;
      int n;
      apb(1'b1, `OFS_STAT, 32'h3);
      arb_at <= 4'h3;
      apb(1'b1, `OFS_BUF, 32'hf0);
      wait_idle;
      stat(32'h7, 32'h1);
      oe_is(2'b00);
      arb_at <= 4'h0;
      repeat (6) @(posedge pclk);
      stat(32'h12, 32'h12);
      apb(1'b1, `OFS_STAT, 32'h2);
      apb(1'b1, `OFS_BUF, 32'h1f);
      n = 0;
      while (scl_oe !== 1'b1 && n < 500)
      begin
         @(posedge pclk);
         n++;
      end
      oe_is(2'b11);
      wait_idle;
   endtask
   // repeated start, ack, stop sequence, then disable
   task automatic t_stop;
      apb(1'b1, `OFS_CTRL, 32'h5);
      wait_idle;
      oe_is(2'b11);
      apb(1'b1, `OFS_CTRL, 32'h11);
      wait_idle;
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(r, 32'h1);
      apb(1'b1, `OFS_STAT, 32'h3);
      apb(1'b1, `OFS_CTRL, 32'h9);
      wait_idle;
      stat(32'h13, 32'h12);
      oe_is(2'b00);
      apb(1'b1, `OFS_CTRL, 32'h0);
      stat(32'h18, 32'h0);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_start_col;
      t_byte;
      t_byte_col;
      t_stop;
      wrap_up;
   end
endmodule // i2c_master_bus_collision_arbiter_tb
bind i2c_master_bus_collision_arbiter i2c_arb_sva i2c_arb_sva_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// [core/bit_rate_counter.v]
// reloadable countdown that marks the end of one bit-rate period
`timescale 1ns/1ps
`default_nettype none
module bit_rate_counter #(
   parameter W = 7
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         load,
   input  wire         run,
   input  wire [W-1:0] reload,
   output wire         expire
);
   reg [W-1:0] cnt_q;

   // load wins, count only while running, park at zero
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= {W{1'b0}};
      else if (load)
         cnt_q <= reload;
      else if (run && (cnt_q != {W{1'b0}}))
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
   end

   // stale count is masked in the load cycle
   assign expire = run & ~load & (cnt_q == {W{1'b0}});
endmodule // bit_rate_counter
`default_nettype wire

// [core/i2c_arb_map.vh]
// register offsets, field positions and reset values of the arbiter port
`ifndef I2C_ARB_MAP_VH
`define I2C_ARB_MAP_VH
// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_STAT      8'h04
`define OFS_RATE      8'h08
`define OFS_BUF       8'h0c
// sequence control register fields
`define CTRL_EN       0
`define CTRL_START    1
`define CTRL_RSTART   2
`define CTRL_STOP     3
`define CTRL_ACK      4
`define CTRL_ACKDT    5
// port status register fields
`define STAT_BCOL     0
`define STAT_EVT      1
`define STAT_BF       2
`define STAT_SSEEN    3
`define STAT_PSEEN    4
`define STAT_BUSY     5
`define STAT_ACKSTAT  6
`define STAT_SDA      7
`define STAT_SCL      8
// reset values
`define RATE_RST      7'h09
`define BUF_RST       8'h00
`endif

// [core/i2c_master_bus_collision_arbiter.v]
// two-wire master port with bus collision detection and arbitration
// Notes on behaviour
// - released data read low is collision
// - collision sets flag, port goes idle
// - byte collision: stop, clear full, release
// - sequence collision: abort, release, clear enable
// - after collision, stop on bus sets event
// - buffer write restarts at first bit
// - start with a low line collides
// - start counts; low clock collides
// - early data low: reset count, drive
// - drive data, recount, then drive clock
// - repeated start: release, count, check data
// - data falling early is no collision
// - clock falling early collides in restart
// - restart: drive data, count, drive clock
// - stop: release clock, count, check data
// - clock low during stop collides
// - counter waits for clock really high
// - seen bits clear on reset, disable
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_arb_map.vh"
module i2c_master_bus_collision_arbiter (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        scl_i,
   output reg         scl_o,
   output reg         scl_oe,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe
);
   localparam [4:0] IDLE    = 5'h00;
   localparam [4:0] ST_CHK  = 5'h01;
   localparam [4:0] ST_W1   = 5'h02;
   localparam [4:0] ST_W2   = 5'h03;
   localparam [4:0] RS_SDA  = 5'h04;
   localparam [4:0] RS_SCL  = 5'h05;
   localparam [4:0] RS_W1   = 5'h06;
   localparam [4:0] RS_W2   = 5'h07;
   localparam [4:0] SP_LOW  = 5'h08;
   localparam [4:0] SP_SCL  = 5'h09;
   localparam [4:0] SP_W1   = 5'h0a;
   localparam [4:0] SP_W2   = 5'h0b;
   localparam [4:0] TX_LOW  = 5'h0c;
   localparam [4:0] TX_REL  = 5'h0d;
   localparam [4:0] TX_HIGH = 5'h0e;
   localparam [4:0] AK_LOW  = 5'h0f;
   localparam [4:0] AK_REL  = 5'h10;
   localparam [4:0] AK_HIGH = 5'h11;

   reg  [4:0] state_q;
   reg  [6:0] rate_q;
   reg  [7:0] shift_q;
   reg  [7:0] buf_q;
   reg  [3:0] bit_cnt_q;
   reg        en_q;
   reg        start_en_q;
   reg        rstart_en_q;
   reg        stop_en_q;
   reg        ack_en_q;
   reg        ack_data_q;
   reg        bcol_q;
   reg        evt_q;
   reg        buf_full_q;
   reg        ack_stat_q;
   reg        start_seen_q;
   reg        stop_seen_q;
   reg        ld_q;
   reg        scl_s1;
   reg        scl_s2;
   reg        scl_s3;
   reg        sda_s1;
   reg        sda_s2;
   reg        sda_s3;
   reg [31:0] rd_val;
   reg        mapped;
   wire       expire;
   wire       run;
   wire       wr_acc;
   wire       bus_start;
   wire       bus_stop;

   // pin synchronisers, third stage only for edge detection
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end
      else
      begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // start and stop conditions seen on the bus
   assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // counting states; release states keep the counter parked
   assign run = (state_q == ST_W1) | (state_q == ST_W2) |
                (state_q == RS_SDA) | (state_q == RS_W1) |
                (state_q == RS_W2) | (state_q == SP_W1) |
                (state_q == SP_W2) | (state_q == TX_LOW) |
                (state_q == TX_HIGH) | (state_q == AK_LOW) |
                (state_q == AK_HIGH);

   bit_rate_counter #(
      .W (7)
   ) u_bit_rate_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (ld_q),
      .run     (run),
      .reload  (rate_q),
      .expire  (expire)
   );

   // write takes effect in the access cycle that shows pready
   assign wr_acc = psel & penable & pwrite & pready;

   // read value and address decode
   always @*
   begin
      rd_val = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL:
         begin
            rd_val[`CTRL_EN]     = en_q;
            rd_val[`CTRL_START]  = start_en_q;
            rd_val[`CTRL_RSTART] = rstart_en_q;
            rd_val[`CTRL_STOP]   = stop_en_q;
            rd_val[`CTRL_ACK]    = ack_en_q;
            rd_val[`CTRL_ACKDT]  = ack_data_q;
         end
         `OFS_STAT:
         begin
            rd_val[`STAT_BCOL]    = bcol_q;
            rd_val[`STAT_EVT]     = evt_q;
            rd_val[`STAT_BF]      = buf_full_q;
            rd_val[`STAT_SSEEN]   = start_seen_q;
            rd_val[`STAT_PSEEN]   = stop_seen_q;
            rd_val[`STAT_BUSY]    = (state_q != IDLE);
            rd_val[`STAT_ACKSTAT] = ack_stat_q;
            rd_val[`STAT_SDA]     = sda_s2;
            rd_val[`STAT_SCL]     = scl_s2;
         end
         `OFS_RATE: rd_val[6:0] = rate_q;
         `OFS_BUF:  rd_val[7:0] = buf_q;
         default:   mapped = 1'b0;
      endcase
   end

   // apb answer: ready in the first access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         scl_o   <= 1'b0;
         sda_o   <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0000_0000;
         scl_o   <= 1'b0; // open drain: only ever pulls low
         sda_o   <= 1'b0;
      end
   end

   // collision: flag, release lines, clear sequence bits, go idle
   task abort;
   begin
      bcol_q      <= 1'b1;
      state_q     <= IDLE;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      buf_full_q  <= 1'b0;
      start_en_q  <= 1'b0;
      rstart_en_q <= 1'b0;
      stop_en_q   <= 1'b0;
      ack_en_q    <= 1'b0;
   end
   endtask

   // register writes and the port sequencer
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q      <= IDLE;
         rate_q       <= `RATE_RST;
         shift_q      <= 8'h00;
         buf_q        <= `BUF_RST;
         bit_cnt_q    <= 4'h0;
         en_q         <= 1'b0;
         start_en_q   <= 1'b0;
         rstart_en_q  <= 1'b0;
         stop_en_q    <= 1'b0;
         ack_en_q     <= 1'b0;
         ack_data_q   <= 1'b0;
         bcol_q       <= 1'b0;
         evt_q        <= 1'b0;
         buf_full_q   <= 1'b0;
         ack_stat_q   <= 1'b0;
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b0;
         ld_q         <= 1'b0;
         scl_oe       <= 1'b0;
         sda_oe       <= 1'b0;
      end
      else
      begin
         ld_q <= 1'b0;
         // software clears; later hardware sets win in the same cycle
         if (wr_acc && paddr == `OFS_STAT)
         begin
            if (pwdata[`STAT_BCOL])
               bcol_q <= 1'b0;
            if (pwdata[`STAT_EVT])
               evt_q <= 1'b0;
         end
         if (wr_acc && paddr == `OFS_RATE)
            rate_q <= pwdata[6:0];
         // sequence bits accepted only while idle
         if (wr_acc && paddr == `OFS_CTRL)
         begin
            en_q       <= pwdata[`CTRL_EN];
            ack_data_q <= pwdata[`CTRL_ACKDT];
            if (state_q == IDLE)
            begin
               start_en_q  <= pwdata[`CTRL_START];
               rstart_en_q <= pwdata[`CTRL_RSTART];
               stop_en_q   <= pwdata[`CTRL_STOP];
               ack_en_q    <= pwdata[`CTRL_ACK];
            end
         end
         // bus conditions keep being watched, also after a collision
         if (bus_start)
         begin
            start_seen_q <= 1'b1;
            stop_seen_q  <= 1'b0;
         end
         if (bus_stop)
         begin
            stop_seen_q  <= 1'b1;
            start_seen_q <= 1'b0;
            evt_q        <= 1'b1;
         end
         if (!en_q)
         begin
            state_q      <= IDLE;
            scl_oe       <= 1'b0;
            sda_oe       <= 1'b0;
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
            start_en_q   <= 1'b0;
            rstart_en_q  <= 1'b0;
            stop_en_q    <= 1'b0;
            ack_en_q     <= 1'b0;
         end
         else
         begin
            case (state_q)
               IDLE:
               begin
                  if (start_en_q)
                  begin
                     scl_oe  <= 1'b0;
                     sda_oe  <= 1'b0;
                     state_q <= ST_CHK;
                  end
                  else if (rstart_en_q)
                  begin
                     sda_oe  <= 1'b0;
                     ld_q    <= 1'b1;
                     state_q <= RS_SDA;
                  end
                  else if (stop_en_q)
                  begin
                     sda_oe  <= 1'b1;
                     state_q <= SP_LOW;
                  end
                  else if (ack_en_q)
                  begin
                     scl_oe  <= 1'b1;
                     sda_oe  <= ~ack_data_q;
                     ld_q    <= 1'b1;
                     state_q <= AK_LOW;
                  end
                  else if (wr_acc && paddr == `OFS_BUF)
                  begin
                     buf_q      <= pwdata[7:0];
                     shift_q    <= pwdata[7:0];
                     bit_cnt_q  <= 4'h0;
                     buf_full_q <= 1'b1;
                     scl_oe     <= 1'b1;
                     sda_oe     <= ~pwdata[7];
                     ld_q       <= 1'b1;
                     state_q    <= TX_LOW;
                  end
               end
               ST_CHK:
               begin
                  if (!sda_s2 || !scl_s2)
                     abort;
                  else
                  begin
                     ld_q    <= 1'b1;
                     state_q <= ST_W1;
                  end
               end
               ST_W1:
               begin
                  if (!sda_s2)
                  begin
                     ld_q    <= 1'b1;
                     sda_oe  <= 1'b1;
                     state_q <= ST_W2;
                  end
                  else if (!scl_s2)
                     abort;
                  else if (expire)
                  begin
                     sda_oe  <= 1'b1;
                     ld_q    <= 1'b1;
                     state_q <= ST_W2;
                  end
               end
               ST_W2:
               begin
                  // low clock here is not a collision
                  if (expire)
                  begin
                     scl_oe     <= 1'b1;
                     start_en_q <= 1'b0;
                     evt_q      <= 1'b1;
                     state_q    <= IDLE;
                  end
               end
               RS_SDA:
               begin
                  if (expire)
                  begin
                     scl_oe  <= 1'b0;
                     state_q <= RS_SCL;
                  end
               end
               RS_SCL:
               begin
                  if (scl_s2)
                  begin
                     if (!sda_s2)
                        abort;
                     else
                     begin
                        ld_q    <= 1'b1;
                        state_q <= RS_W1;
                     end
                  end
               end
               RS_W1:
               begin
                  // another master pulling data low early is tolerated
                  if (!scl_s2)
                     abort;
                  else if (expire)
                  begin
                     sda_oe  <= 1'b1;
                     ld_q    <= 1'b1;
                     state_q <= RS_W2;
                  end
               end
               RS_W2:
               begin
                  if (expire)
                  begin
                     scl_oe      <= 1'b1;
                     rstart_en_q <= 1'b0;
                     evt_q       <= 1'b1;
                     state_q     <= IDLE;
                  end
               end
               SP_LOW:
               begin
                  if (!sda_s2)
                  begin
                     scl_oe  <= 1'b0;
                     state_q <= SP_SCL;
                  end
               end
               SP_SCL:
               begin
                  if (scl_s2)
                  begin
                     ld_q    <= 1'b1;
                     state_q <= SP_W1;
                  end
               end
               SP_W1:
               begin
                  if (!scl_s2)
                     abort;
                  else if (expire)
                  begin
                     sda_oe  <= 1'b0;
                     ld_q    <= 1'b1;
                     state_q <= SP_W2;
                  end
               end
               SP_W2:
               begin
                  if (expire)
                  begin
                     if (!sda_s2)
                        abort;
                     else
                     begin
                        stop_en_q <= 1'b0;
                        evt_q     <= 1'b1;
                        state_q   <= IDLE;
                     end
                  end
               end
               TX_LOW:
               begin
                  if (expire)
                  begin
                     scl_oe  <= 1'b0;
                     state_q <= TX_REL;
                  end
               end
               TX_REL:
               begin
                  if (scl_s2)
                  begin
                     ld_q    <= 1'b1;
                     state_q <= TX_HIGH;
                  end
               end
               TX_HIGH:
               begin
                  if (!sda_oe && !sda_s2 && bit_cnt_q != 4'h8)
                     abort;
                  else if (expire)
                  begin
                     scl_oe <= 1'b1;
                     if (bit_cnt_q == 4'h8)
                     begin
                        ack_stat_q <= sda_s2;
                        buf_full_q <= 1'b0;
                        evt_q      <= 1'b1;
                        sda_oe     <= 1'b0;
                        state_q    <= IDLE;
                     end
                     else
                     begin
                        shift_q   <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        // ninth bit releases data for the answer
                        sda_oe    <= (bit_cnt_q == 4'h7) ? 1'b0 :
                                     ~shift_q[6];
                        ld_q      <= 1'b1;
                        state_q   <= TX_LOW;
                     end
                  end
               end
               AK_LOW:
               begin
                  if (expire)
                  begin
                     scl_oe  <= 1'b0;
                     state_q <= AK_REL;
                  end
               end
               AK_REL:
               begin
                  if (scl_s2)
                  begin
                     ld_q    <= 1'b1;
                     state_q <= AK_HIGH;
                  end
               end
               AK_HIGH:
               begin
                  if (!sda_oe && !sda_s2)
                     abort;
                  else if (expire)
                  begin
                     scl_oe   <= 1'b1;
                     ack_en_q <= 1'b0;
                     evt_q    <= 1'b1;
                     state_q  <= IDLE;
                  end
               end
               default:
                  state_q <= IDLE;
            endcase
         end
      end
   end
endmodule // i2c_master_bus_collision_arbiter
`default_nettype wire
